// [bpb_bridge.sv]
// Peripheral access latency bridge: decodes each system bus access and
// stalls the master for the cycle count of its region and clock.
// Assumes one request at a time and ratio inputs steady during accesses.
// Notes on behaviour
// - Lowest control region takes two core cycles
// - Converter region five read, four write cycles
// - Fractional spans use truncated low, rounded-up high
// - Serial 16-bit registers cost two more cycles
// - Serial byte accesses keep the base count
// - SPI 32-bit data access costs two more
// - SPI narrow data accesses keep the base count
// - Open quad-SPI accesses wait for bus idle
// - Faster core adds peripheral-clock synchronisation cycle
// - Equal clocks give constant synchronisation cycles
// - Write counts are non-bufferable, master waits
`timescale 1ns/1ps
module bpb_bridge import bpb_pkg::*; #(
  parameter int DIV_W = DIV_W_DEF
) (
  input  wire logic             CORE_CLK_I,     // Core clock, 200 MHz
  input  wire logic             RST_I,          // Asynchronous reset
  input  wire logic             REQ_VALID_I,    // Request strobe
  input  wire bpb_req_t         REQ_I,          // Request fields
  input  wire logic [DIV_W-1:0] DIV_A_I,        // Peripheral clock A ratio
  input  wire logic [DIV_W-1:0] DIV_B_I,        // Peripheral clock B ratio
  input  wire logic [DIV_W-1:0] DIV_F_I,        // Flash clock ratio
  input  wire logic             QSPI_BUSY_I,    // Quad-SPI bus active
  input  wire logic [31:0]      PERIPH_RDATA_I, // Read data from target
  output logic                  BUSY_O,         // Access in flight
  output logic                  ACK_O,          // Access complete pulse
  output logic                  ERR_O,          // Unmapped address
  output logic [31:0]           RDATA_O,        // Read data to master
  output logic                  PERIPH_SEL_O,   // Downstream select
  output bpb_req_t              PERIPH_O        // Downstream access
);

  bpb_st_t          st_q;         // Registered state
  bpb_st_t          st_d;         // Next state
  logic             tick_a;       // Peripheral clock A boundary
  logic             tick_b;       // Peripheral clock B boundary
  logic             tick_f;       // Flash clock boundary
  logic             en;           // Boundary of the access's clock
  logic             take;         // Request accepted this cycle
  logic             hit;          // Address decoded to a region
  bpb_row_t         row;          // Decoded region row
  logic             eq_now;       // Region clock equals core clock
  logic [4:0]       base;         // Base count for this access
  logic [CNT_W-1:0] total;        // Count after wide-register extra

  localparam logic [DIV_W-1:0] RATIO_ONE = DIV_W'(1);

  // One divider per slow clock
  bpb_pace #(.W(DIV_W)) u_pace_a (
    .clk_i   (CORE_CLK_I),
    .rst_i   (RST_I),
    .ratio_i (DIV_A_I),
    .tick_o  (tick_a)
  );

  bpb_pace #(.W(DIV_W)) u_pace_b (
    .clk_i   (CORE_CLK_I),
    .rst_i   (RST_I),
    .ratio_i (DIV_B_I),
    .tick_o  (tick_b)
  );

  bpb_pace #(.W(DIV_W)) u_pace_f (
    .clk_i   (CORE_CLK_I),
    .rst_i   (RST_I),
    .ratio_i (DIV_F_I),
    .tick_o  (tick_f)
  );

  // Decode and pick the count for an incoming request
  always_comb begin
    row    = bpb_decode(REQ_I.addr, hit);
    take   = REQ_VALID_I && (st_q.fsm == S_IDLE);
    unique case (row.unit)
      UC: eq_now = 1'b1;
      UA: eq_now = DIV_A_I <= RATIO_ONE;
      UB: eq_now = DIV_B_I <= RATIO_ONE;
      UF: eq_now = DIV_F_I <= RATIO_ONE;
    endcase
    // Fast rows hold the rounded-up top of each span
    if (!hit) begin
      base = UNMAP_CYC;
    end else if (eq_now) begin
      base = REQ_I.we ? row.wr_eq : row.rd_eq;
    end else begin
      base = REQ_I.we ? row.wr_fx : row.rd_fx;
    end
    total = {1'b0, base};
    // Halfword serial registers and word SPI data cost extra
    if (hit && row.kind == KS && REQ_I.size == SZ_HALF) begin
      total = total + ADD_CYC;
    end else if (hit && row.kind == KP && REQ_I.size == SZ_WORD) begin
      total = total + ADD_CYC;
    end
    // Byte serial and narrow SPI accesses fall through at base count
  end

  // Boundary pulse of the clock that the current access counts in
  always_comb begin
    if (st_q.eq) begin
      en = 1'b1;
    end else begin
      unique case (st_q.unit)
        UC: en = 1'b1;
        UA: en = tick_a;
        UB: en = tick_b;
        UF: en = tick_f;
      endcase
    end
  end

  // Sequencer: take, synchronise, count, optionally hold, answer
  always_comb begin
    st_d     = st_q;
    st_d.ack = 1'b0;
    unique case (st_q.fsm)
      S_IDLE: begin
        if (take) begin
          st_d.req  = REQ_I;
          st_d.err  = !hit;
          st_d.unit = hit ? row.unit : UC;
          st_d.eq   = hit ? eq_now : 1'b1;
          st_d.cnt  = total - CNT_OFS;
          st_d.opn  = hit && (row.kind == KB ||
                              (row.kind == KW && REQ_I.we));
          // Equal clocks skip the synchroniser so the count is fixed
          st_d.fsm  = st_d.eq ? S_COUNT : S_SYNC;
        end
      end
      S_SYNC: begin
        // Wait out the partial slow period before counting
        if (en) begin
          st_d.fsm = S_COUNT;
        end
      end
      S_COUNT: begin
        if (en) begin
          if (st_q.cnt != '0) begin
            st_d.cnt = st_q.cnt - CNT_W'(1);
          end else if (st_q.opn && QSPI_BUSY_I) begin
            // A quiet bus answers at the minimum count, no extra cycle
            st_d.fsm = S_HOLD;
          end else begin
            st_d.fsm   = S_IDLE;
            st_d.ack   = 1'b1;
            st_d.rdata = (st_q.req.we || st_q.err) ? '0 : PERIPH_RDATA_I;
          end
        end
      end
      S_HOLD: begin
        // Quad-SPI register stays busy until its bus goes quiet
        if (!QSPI_BUSY_I) begin
          st_d.fsm   = S_IDLE;
          st_d.ack   = 1'b1;
          st_d.rdata = st_q.req.we ? '0 : PERIPH_RDATA_I;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs: error held until the next take, data until the next answer
  assign BUSY_O       = st_q.fsm != S_IDLE;
  assign ACK_O        = st_q.ack;
  assign ERR_O        = st_q.err;
  assign RDATA_O      = st_q.rdata;
  assign PERIPH_SEL_O = BUSY_O && !st_q.err;
  assign PERIPH_O     = st_q.req;

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);

  property p_ctrl_two;
    take && REQ_I.addr >= CTRL_LO && REQ_I.addr <= CTRL_HI
      |=> !ACK_O ##1 ACK_O;
  endproperty
  a_ctrl_two: assert property (p_ctrl_two)
    else $error("control region access not two cycles");

  property p_adc_read_eq;
    take && REQ_I.addr == ADC_BASE && !REQ_I.we && DIV_A_I <= RATIO_ONE
      |=> !ACK_O [*4] ##1 ACK_O;
  endproperty
  a_adc_read_eq: assert property (p_adc_read_eq)
    else $error("converter read not five cycles");

  property p_adc_write_eq;
    take && REQ_I.addr == ADC_BASE && REQ_I.we && DIV_A_I <= RATIO_ONE
      |=> !ACK_O [*3] ##1 ACK_O;
  endproperty
  a_adc_write_eq: assert property (p_adc_write_eq)
    else $error("converter write not four cycles");

  property p_sci_half;
    take && REQ_I.addr[31:12] == SCI_BASE[31:12] && !REQ_I.we &&
      REQ_I.size == SZ_HALF && DIV_A_I <= RATIO_ONE
      |=> !ACK_O [*6] ##1 ACK_O;
  endproperty
  a_sci_half: assert property (p_sci_half)
    else $error("serial halfword read lacks two extra cycles");

  property p_sci_byte;
    take && REQ_I.addr[31:12] == SCI_BASE[31:12] && !REQ_I.we &&
      REQ_I.size == SZ_BYTE && DIV_A_I <= RATIO_ONE
      |=> !ACK_O [*4] ##1 ACK_O;
  endproperty
  a_sci_byte: assert property (p_sci_byte)
    else $error("serial byte read not at base count");

  property p_spi_word;
    take && REQ_I.addr[31:12] == SPI_BASE[31:12] && !REQ_I.we &&
      REQ_I.size == SZ_WORD && DIV_A_I <= RATIO_ONE
      |=> !ACK_O [*6] ##1 ACK_O;
  endproperty
  a_spi_word: assert property (p_spi_word)
    else $error("SPI word read lacks two extra cycles");

  property p_spi_half;
    take && REQ_I.addr[31:12] == SPI_BASE[31:12] && REQ_I.we &&
      REQ_I.size == SZ_HALF && DIV_A_I <= RATIO_ONE
      |=> !ACK_O [*3] ##1 ACK_O;
  endproperty
  a_spi_half: assert property (p_spi_half)
    else $error("SPI narrow write not at base count");

  property p_qspi_hold;
    st_q.fsm == S_HOLD && QSPI_BUSY_I |=> !ACK_O && BUSY_O;
  endproperty
  a_qspi_hold: assert property (p_qspi_hold)
    else $error("quad-SPI access answered while bus busy");

  property p_sync_wait;
    st_q.fsm == S_SYNC && !en |=> st_q.fsm == S_SYNC && !ACK_O;
  endproperty
  a_sync_wait: assert property (p_sync_wait)
    else $error("synchroniser left without slow clock boundary");

  property p_eq_nosync;
    take && eq_now |=> st_q.fsm != S_SYNC;
  endproperty
  a_eq_nosync: assert property (p_eq_nosync)
    else $error("equal clocks entered synchroniser");

  property p_ack_once;
    ACK_O |-> $past(BUSY_O) && !BUSY_O ##1 !ACK_O;
  endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("answer without a stalled access");

  c_ctrl:  cover property (take && REQ_I.addr == CTRL_LO ##2 ACK_O);
  c_hold:  cover property (st_q.fsm == S_HOLD ##1 ACK_O);
  c_sync:  cover property (st_q.fsm == S_SYNC ##1 st_q.fsm == S_COUNT);
  c_err:   cover property (ACK_O && ERR_O);

endmodule

// [bpb_bridge_tb.sv]
// Self-checking bench for the access latency bridge.
// Assumes one request at a time and ratio inputs changed only when idle.
`timescale 1ns/1ps
module bpb_bridge_tb import bpb_pkg::*; ;
  logic        clk;       // Core clock
  logic        rst;       // Reset, high
  logic        valid;     // Request strobe
  bpb_req_t    req;       // Request fields
  logic [3:0]  div_a;     // Clock A ratio
  logic [3:0]  div_b;     // Clock B ratio
  logic [3:0]  div_f;     // Flash clock ratio
  logic [7:0]  busy_len;  // Quad-SPI busy span for the model
  logic [31:0] prd;       // Target read data
  logic        qbusy;     // Quad-SPI busy
  logic        busy;      // Bridge busy
  logic        ack;       // Completion pulse
  logic        err;       // Unmapped flag
  logic [31:0] rdata;     // Read data to master
  logic        sel;       // Downstream select
  bpb_req_t    pout;      // Downstream access
  int          err_count   = 0;
  int          check_count = 0;
  int          lat;       // Cycles from take to answer
  logic [31:0] rd;        // Read data at the answer
  logic        er;        // Error flag at the answer
  logic        sl;        // Select seen during the access
  logic        bs;        // Busy held through the wait
  logic        qb;        // Busy level in the cycle before the answer

  bpb_bridge bpb_bridge_inst (
    .CORE_CLK_I(clk), .RST_I(rst), .REQ_VALID_I(valid), .REQ_I(req),
    .DIV_A_I(div_a), .DIV_B_I(div_b), .DIV_F_I(div_f),
    .QSPI_BUSY_I(qbusy), .PERIPH_RDATA_I(prd), .BUSY_O(busy),
    .ACK_O(ack), .ERR_O(err), .RDATA_O(rdata), .PERIPH_SEL_O(sel),
    .PERIPH_O(pout));

  bpb_target_model bpb_target_model_inst (
    .clk_i(clk), .rst_i(rst), .sel_i(sel), .acc_i(pout),
    .busy_len_i(busy_len), .rdata_o(prd), .qspi_busy_o(qbusy));

  // 200 MHz core clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Verdict in one place
  task automatic final_report();
    if (err_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Compare a data word
  task automatic chk_w(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Compare a cycle count against a span
  task automatic chk_n(input string nm, input int lo, input int hi,
                       input int g);
    check_count++;
    if (g < lo || g > hi) begin
      err_count++;
      $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask

  // One access: strobe for one take edge, then wait for the answer.
  // The wait is bounded so a hung bridge ends the run.
  task automatic access(input logic w, input logic [1:0] sz,
                        input logic [31:0] a);
    @(negedge clk);
    valid = 1'b1;
    req   = '{w, sz, a, ~a};
    @(negedge clk);
    valid = 1'b0;
    lat   = 1;
    sl    = 1'b0;
    bs    = 1'b1;
    qb    = 1'b1;
    while (ack !== 1'b1) begin
      if (lat >= 200) begin
        err_count++;
        final_report();
      end
      sl = sl | sel;
      bs = bs & busy;
      qb = qbusy;
      @(negedge clk);
      lat++;
    end
    rd = rdata;
    er = err;
  endtask

  // Equal clocks over many regions, reads and writes
  task automatic t_table();
    logic [31:0] ad [8] = '{32'h4000_0000, 32'h4008_3000, 32'h4001_e400,
                            32'h4009_4000, 32'h4017_0000, 32'h6400_0804,
                            32'h407f_c000, 32'h400e_8000};
    int nr [8] = '{2, 5, 9, 4, 5, 4, 3, 7};
    int nw [8] = '{2, 4, 8, 3, 4, 3, 3, 4};
    for (int i = 0; i < 8; i++) begin
      access(1'b0, SZ_WORD, ad[i]);
      chk_n("read cycles", nr[i], nr[i], lat);
      chk_w("read data", {ad[i][15:0], ~ad[i][15:0]}, rd);
      chk_w("select and busy held", 32'h3, {30'h0, bs, sl});
      chk_w("busy after answer", 32'h0, {31'h0, busy});
      access(1'b1, SZ_WORD, ad[i]);
      chk_n("write cycles", nw[i], nw[i], lat);
      chk_w("write data out", ~ad[i], pout.wdata);
      chk_w("address out", ad[i], pout.addr);
      chk_w("write read data", 32'h0, rd);
    end
  endtask

  // Control region ignores slow peripheral clocks, both ends of range
  task automatic t_ctrl();
    @(negedge clk);
    div_a = 4'h3;
    div_b = 4'h3;
    div_f = 4'h3;
    access(1'b0, SZ_WORD, CTRL_LO);
    chk_n("ctrl read cycles", 2, 2, lat);
    access(1'b1, SZ_BYTE, CTRL_HI);
    chk_n("ctrl write cycles", 2, 2, lat);
    div_b = 4'h1;
    div_f = 4'h1;
  endtask

  // Slower clocks: span in core cycles with a sync period added
  task automatic t_slow();
    div_a = 4'h2;
    div_b = 4'h2;
    div_f = 4'h2;
    access(1'b0, SZ_WORD, ADC_BASE);
    chk_n("slow adc read", 9, 11, lat);
    access(1'b1, SZ_WORD, ADC_BASE + 32'h4);
    chk_n("slow adc write", 7, 9, lat);
    access(1'b0, SZ_WORD, 32'h407f_c000);
    chk_n("slow flash read", 5, 7, lat);
    access(1'b0, SZ_WORD, 32'h4001_e400);
    chk_n("slow clock b read", 15, 17, lat);
    div_a = 4'h1;
    div_b = 4'h1;
    div_f = 4'h1;
    access(1'b0, SZ_WORD, ADC_BASE);
    chk_n("adc read equal", 5, 5, lat);
  endtask

  // Serial unit: halfword costs two more, byte keeps base count
  task automatic t_sci();
    access(1'b0, SZ_HALF, SCI_BASE + 32'h30e);
    chk_n("serial half read", 7, 7, lat);
    access(1'b1, SZ_HALF, SCI_BASE + 32'h30e);
    chk_n("serial half write", 6, 6, lat);
    access(1'b0, SZ_BYTE, SCI_BASE + 32'h30f);
    chk_n("serial byte read", 5, 5, lat);
    access(1'b1, SZ_BYTE, SCI_BASE + 32'h30e);
    chk_n("serial byte write", 4, 4, lat);
  endtask

  // SPI unit: word data costs two more, narrow keeps base count
  task automatic t_spi();
    access(1'b0, SZ_WORD, SPI_BASE + 32'h4);
    chk_n("spi word read", 7, 7, lat);
    access(1'b1, SZ_WORD, SPI_BASE + 32'h4);
    chk_n("spi word write", 6, 6, lat);
    access(1'b0, SZ_HALF, SPI_BASE + 32'h4);
    chk_n("spi half read", 5, 5, lat);
    access(1'b1, SZ_BYTE, SPI_BASE + 32'h4);
    chk_n("spi byte write", 4, 4, lat);
  endtask

  // Open quad-SPI rows: minimum count, then wait for the bus to idle
  task automatic t_qspi();
    busy_len = 8'd0;
    access(1'b1, SZ_WORD, 32'h6400_0020);
    chk_n("qspi write min", 14, 14, lat);
    access(1'b0, SZ_WORD, QSPI_OPEN);
    chk_n("qspi read min", 25, 25, lat);
    busy_len = 8'd30;
    access(1'b1, SZ_WORD, 32'h6400_0000);
    chk_n("qspi write held", 31, 34, lat);
    chk_w("qspi idle before ack", 32'h0, {31'h0, qb});
    busy_len = 8'd40;
    access(1'b0, SZ_WORD, QSPI_OPEN);
    chk_n("qspi read held", 41, 44, lat);
    busy_len = 8'd0;
  endtask

  // Unmapped address is answered fast with an error, no downstream
  task automatic t_unmapped();
    access(1'b0, SZ_WORD, 32'h5000_0000);
    chk_n("unmapped cycles", 2, 2, lat);
    chk_w("unmapped flag", 32'h1, {31'h0, er});
    chk_w("unmapped data", 32'h0, rd);
    chk_w("unmapped select", 32'h0, {31'h0, sl});
    access(1'b0, SZ_WORD, CTRL_LO);
    chk_w("flag cleared", 32'h0, {31'h0, er});
  endtask

  // Strobe held high: taken at cycle 0 and in the answer cycle only
  task automatic t_b2b();
    logic [15:0] seen;
    seen = 16'h0;
    @(negedge clk);
    valid = 1'b1;
    req   = '{1'b1, SZ_WORD, ADC_BASE + 32'h10, 32'h0000_00a5};
    for (int k = 1; k < 15; k++) begin
      @(negedge clk);
      seen[k] = ack;
      if (k == 5) begin
        valid = 1'b0;
      end
    end
    chk_w("back to back acks", 32'h0000_0110, {16'h0, seen});
  endtask

  // Reset in mid-access clears every output, then a fresh access works
  task automatic t_reset();
    @(negedge clk);
    valid = 1'b1;
    req   = '{1'b0, SZ_WORD, ADC_BASE, 32'h0};
    @(negedge clk);
    valid = 1'b0;
    @(negedge clk);
    rst = 1'b1;
    @(negedge clk);
    chk_w("outputs in reset", 32'h0,
          {28'h0, busy, ack, err, sel} | rdata);
    rst = 1'b0;
    access(1'b0, SZ_WORD, CTRL_LO);
    chk_n("ctrl after reset", 2, 2, lat);
  endtask

  // Main sequence
  initial begin
    rst      = 1'b1;
    valid    = 1'b0;
    req      = '0;
    div_a    = 4'h1;
    div_b    = 4'h1;
    div_f    = 4'h1;
    busy_len = 8'd0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_table();
    t_ctrl();
    t_slow();
    t_sci();
    t_spi();
    t_qspi();
    t_unmapped();
    t_b2b();
    t_reset();
    final_report();
  end
endmodule

// [bpb_pace.sv]
// Clock-enable divider: one-cycle tick per slow clock period.
// Assumes the ratio input is steady while accesses are in flight.
`timescale 1ns/1ps
module bpb_pace #(
  parameter int W = 4
) (
  input  wire logic         clk_i,    // Core clock
  input  wire logic         rst_i,    // Asynchronous reset, high
  input  wire logic [W-1:0] ratio_i,  // Divide factor, 0 or 1 is equal
  output logic              tick_o    // Slow clock period boundary
);

  localparam logic [W-1:0] ONE = W'(1);

  logic [W-1:0] cnt_q;                // Phase within the slow period
  logic [W-1:0] cnt_d;                // Next phase

  // Wrap at the last phase; a ratio of one ticks every cycle
  always_comb begin
    if (ratio_i <= ONE || cnt_q >= ratio_i - ONE) begin
      cnt_d  = '0;
      tick_o = 1'b1;
    end else begin
      cnt_d  = cnt_q + ONE;
      tick_o = 1'b0;
    end
  end

  // Phase register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule

// [bpb_pkg.sv]
// Constants, types and region latency table for the peripheral access
// latency bridge. Assumes a single 200 MHz core clock domain.
package bpb_pkg;

  // Core clock rate, used only to document the cycle figures
  localparam int          CORE_CLK_MHZ = 200;
  localparam int          DIV_W_DEF    = 4;     // Width of a divide ratio
  localparam int          CNT_W        = 6;     // Width of the down-counter

  // Access sizes carried with each request
  localparam logic [1:0]  SZ_BYTE = 2'h0;
  localparam logic [1:0]  SZ_HALF = 2'h1;
  localparam logic [1:0]  SZ_WORD = 2'h2;

  // Reference clock of a region
  localparam logic [1:0]  UC = 2'h0;            // Core clock
  localparam logic [1:0]  UA = 2'h1;            // Peripheral clock A
  localparam logic [1:0]  UB = 2'h2;            // Peripheral clock B
  localparam logic [1:0]  UF = 2'h3;            // Flash interface clock

  // Region kinds; serial and SPI kinds add to the base count, quad-SPI kinds may hold
  localparam logic [2:0]  KN = 3'h0;            // Plain region
  localparam logic [2:0]  KS = 3'h1;            // Serial comm unit
  localparam logic [2:0]  KP = 3'h2;            // SPI unit
  localparam logic [2:0]  KW = 3'h3;            // Quad-SPI, open write
  localparam logic [2:0]  KB = 3'h4;            // Quad-SPI, open both

  localparam logic [CNT_W-1:0] ADD_CYC   = 6'h02; // Extra for wide regs
  localparam logic [CNT_W-1:0] CNT_OFS   = 6'h02; // Take and answer edges
  localparam logic [4:0]       UNMAP_CYC = 5'h02; // Unmapped answer time

  // Addresses the checks refer to
  localparam logic [31:0] CTRL_LO   = 32'h4000_0000;
  localparam logic [31:0] CTRL_HI   = 32'h4000_6fff;
  localparam logic [31:0] ADC_BASE  = 32'h4017_0000;
  localparam logic [31:0] SCI_BASE  = 32'h4011_8000;
  localparam logic [31:0] SPI_BASE  = 32'h4011_a000;
  localparam logic [31:0] QSPI_OPEN = 32'h6400_0010;

  // One request or downstream access
  typedef struct packed {
    logic        we;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } bpb_req_t;

  // One row of the latency table; fast counts hold the rounded-up maximum
  typedef struct packed {
    logic [31:0] lo;
    logic [31:0] hi;
    logic [1:0]  unit;
    logic [4:0]  rd_eq;
    logic [4:0]  wr_eq;
    logic [4:0]  rd_fx;
    logic [4:0]  wr_fx;
    logic [2:0]  kind;
  } bpb_row_t;

  localparam int NROWS = 25;

  // Earlier rows win where ranges overlap
  localparam bpb_row_t ROWS [NROWS] = '{
    '{32'h4000_0000, 32'h4000_6fff, UC, 5'h02, 5'h02, 5'h02, 5'h02, KN},
    '{32'h4000_8000, 32'h4001_cfff, UC, 5'h04, 5'h03, 5'h04, 5'h03, KN},
    '{32'h4001_e000, 32'h4001_e3ff, UC, 5'h05, 5'h04, 5'h05, 5'h04, KN},
    '{32'h4001_e400, 32'h4001_e5ff, UB, 5'h09, 5'h08, 5'h08, 5'h08, KN},
    '{32'h4008_0000, 32'h4008_0fff, UB, 5'h05, 5'h04, 5'h05, 5'h04, KN},
    '{32'h4008_2000, 32'h4008_3fff, UB, 5'h05, 5'h04, 5'h05, 5'h04, KN},
    '{32'h4008_4000, 32'h4008_4fff, UB, 5'h05, 5'h04, 5'h05, 5'h04, KN},
    '{32'h4008_a000, 32'h4008_afff, UB, 5'h05, 5'h04, 5'h05, 5'h04, KN},
    '{32'h4009_0000, 32'h4009_3fff, UB, 5'h06, 5'h05, 5'h06, 5'h05, KN},
    '{32'h4009_4000, 32'h4009_4fff, UB, 5'h04, 5'h03, 5'h04, 5'h03, KN},
    '{32'h4009_2000, 32'h4009_ffff, UB, 5'h05, 5'h04, 5'h05, 5'h04, KN},
    '{32'h400a_8000, 32'h400a_9fff, UB, 5'h05, 5'h04, 5'h05, 5'h04, KN},
    '{32'h400e_0000, 32'h400e_0fff, UB, 5'h05, 5'h04, 5'h05, 5'h04, KN},
    '{32'h400e_8000, 32'h400e_8fff, UB, 5'h07, 5'h04, 5'h07, 5'h04, KN},
    '{32'h4010_8000, 32'h4010_9fff, UA, 5'h05, 5'h04, 5'h05, 5'h04, KN},
    '{32'h4011_8000, 32'h4011_8fff, UA, 5'h05, 5'h04, 5'h05, 5'h04, KS},
    '{32'h4011_a000, 32'h4011_afff, UA, 5'h05, 5'h04, 5'h05, 5'h04, KP},
    '{32'h4016_1000, 32'h4016_1fff, UA, 5'h06, 5'h04, 5'h06, 5'h04, KN},
    '{32'h4016_9000, 32'h4016_9fff, UA, 5'h07, 5'h04, 5'h07, 5'h04, KN},
    '{32'h4017_0000, 32'h4017_2fff, UA, 5'h05, 5'h04, 5'h05, 5'h04, KN},
    '{32'h6400_0000, 32'h6400_000f, UA, 5'h05, 5'h0e, 5'h05, 5'h0e, KW},
    '{32'h6400_0010, 32'h6400_0013, UA, 5'h19, 5'h06, 5'h19, 5'h05, KB},
    '{32'h6400_0014, 32'h6400_0037, UA, 5'h05, 5'h0e, 5'h05, 5'h0e, KW},
    '{32'h6400_0804, 32'h6400_0807, UA, 5'h04, 5'h03, 5'h04, 5'h03, KN},
    '{32'h407f_c000, 32'h407f_efff, UF, 5'h03, 5'h03, 5'h03, 5'h03, KN}
  };

  // Bridge sequencer states
  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_SYNC  = 2'b01,
    S_COUNT = 2'b10,
    S_HOLD  = 2'b11
  } bpb_fsm_t;

  // Whole state of the bridge
  typedef struct packed {
    bpb_fsm_t          fsm;
    logic              eq;
    logic [1:0]        unit;
    logic [CNT_W-1:0]  cnt;
    logic              opn;
    logic              err;
    logic              ack;
    bpb_req_t          req;
    logic [31:0]       rdata;
  } bpb_st_t;

  // Look up the row of an address; hit is low when nothing matches
  function automatic bpb_row_t bpb_decode(input logic [31:0] a,
                                          output logic hit);
    bpb_row_t r;
    r   = ROWS[0];
    hit = 1'b0;
    for (int i = NROWS - 1; i >= 0; i--) begin
      if (a >= ROWS[i].lo && a <= ROWS[i].hi) begin
        r   = ROWS[i];
        hit = 1'b1;
      end
    end
    return r;
  endfunction

endpackage

// [bpb_target_model.sv]
// Downstream target model: answers reads and drives quad-SPI busy.
// Assumes the bridge's select and registered access outputs.
`timescale 1ns/1ps
module bpb_target_model import bpb_pkg::*; (
  input  wire logic       clk_i,       // Core clock
  input  wire logic       rst_i,       // Reset, high
  input  wire logic       sel_i,       // Downstream select
  input  wire bpb_req_t   acc_i,       // Downstream access
  input  wire logic [7:0] busy_len_i,  // Quad-SPI busy span in cycles
  output logic [31:0]     rdata_o,     // Read data
  output logic            qspi_busy_o  // Quad-SPI bus active
);
  logic [7:0]  left_q;  // Busy cycles still to run
  logic [31:0] junk_q;  // Moves every cycle while not selected
  logic        sel_q;   // Select one cycle ago

  // Data is only held while selected; a moving pattern otherwise, so a
  // stale sample can never pass for a match
  assign rdata_o     = sel_i ? {acc_i.addr[15:0], ~acc_i.addr[15:0]}
                             : junk_q;
  assign qspi_busy_o = (left_q != 8'h00);

  // Busy span starts on the first selected cycle of a quad-SPI access
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      left_q <= 8'h00;
      junk_q <= 32'h5a5a_0f0f;
      sel_q  <= 1'b0;
    end else begin
      sel_q  <= sel_i;
      junk_q <= ~junk_q + 32'h0000_0001;
      if (sel_i && !sel_q && acc_i.addr[31:24] == 8'h64) begin
        left_q <= busy_len_i;
      end else if (left_q != 8'h00) begin
        left_q <= left_q - 8'h01;
      end
    end
  end
endmodule
